// *** hdl/sram_cfg.svh ***
/*
  Constants of the synchronous SRAM write-decode and output-enable block:
  array geometry, lane layout, register byte offsets, field positions, reset values.
  Assumes it is included by bare name from the package and the modules.
*/
`ifndef SRAM_CFG_SVH
`define SRAM_CFG_SVH

// ----------------------------------------
// Array geometry
// ----------------------------------------
`define SRAM_ADDR_W 18
`define SRAM_DEPTH 262144
`define SRAM_LANES 2
`define SRAM_LANE_W 9
`define SRAM_DATA_W 18

// ----------------------------------------
// Register bus
// ----------------------------------------
`define REG_ADDR_W 4
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_WCOUNT 4'h8
`define CTRL_ENABLE_BIT 0
`define CTRL_ENABLE_RST 1'b1
`define STATUS_CYCLE_LSB 0
`define STATUS_STROBE_LSB 2
`define WCOUNT_W 16

`endif

// *** hdl/sram_pkg.sv ***
/*
  Types of the synchronous SRAM write-decode and output-enable block.
  Assumes sram_cfg.svh is on the include path.
*/
`include "sram_cfg.svh"

package sram_pkg;

  // ----------------------------------------
  // Cycle type of the current clock period
  // ----------------------------------------
  typedef enum logic [1:0] {CYC_IDLE, CYC_READ, CYC_WRITE} cycle_t;

  typedef logic [`SRAM_LANES-1:0] lane_mask_t;

endpackage

// *** hdl/sram_write_decode_oe_control.sv ***
/*
  Synchronous burst SRAM core with two 9-bit lanes (8 data bits plus parity):
  write decode, address-strobe cycle start, asynchronous output-enable drive
  control, and an Avalon-MM register slave with waitrequest.
  Assumes all pins except out_en_n_i are synchronous to clk_i; the shared data
  wire is resolved outside from dq_o and dq_oe_o.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sram_cfg.svh"

module sram_write_decode_oe_control
  import sram_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic chip_sel_n_i,
  input wire logic processor_addr_strobe_n_i,
  input wire logic controller_addr_strobe_n_i,
  input wire logic global_write_n_i,
  input wire logic lane_write_gate_n_i,
  input wire logic lane_a_write_n_i,
  input wire logic lane_b_write_n_i,
  input wire logic out_en_n_i,
  input wire logic [`SRAM_ADDR_W-1:0] addr_i,
  input wire logic [`SRAM_DATA_W-1:0] dq_i,
  output logic [`SRAM_DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  input wire logic [`REG_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  write_ctl_if wc();

  assign wc.global_write_n = global_write_n_i;
  assign wc.lane_write_gate_n = lane_write_gate_n_i;
  assign wc.lane_a_write_n = lane_a_write_n_i;
  assign wc.lane_b_write_n = lane_b_write_n_i;

  write_decode write_decode_inst (
    .ctl(wc.decoder)
  );

  // ----------------------------------------
  // Cycle state
  // ----------------------------------------
  cycle_t cycle;
  cycle_t next_cycle;
  logic [`SRAM_ADDR_W-1:0] line_addr;
  logic [`SRAM_ADDR_W-1:0] next_line_addr;
  lane_mask_t last_strobe;
  lane_mask_t next_last_strobe;
  logic [`WCOUNT_W-1:0] wcount;
  logic [`WCOUNT_W-1:0] next_wcount;
  logic ctrl_enable;
  logic do_write;
  lane_mask_t write_strobe;

  always_comb
  begin
    next_cycle = cycle;
    next_line_addr = line_addr;
    do_write = 1'b0;
    if (!processor_addr_strobe_n_i || !controller_addr_strobe_n_i)
    begin
      if (chip_sel_n_i || !ctrl_enable)
      begin
        next_cycle = CYC_IDLE;
      end
      else
      begin
        next_line_addr = addr_i;
        if (!processor_addr_strobe_n_i)
        begin
          next_cycle = CYC_READ;
        end
        else if (wc.is_write)
        begin
          next_cycle = CYC_WRITE;
          do_write = 1'b1;
        end
        else
        begin
          next_cycle = CYC_READ;
        end
      end
    end
    else if (cycle != CYC_IDLE)
    begin
      // Clocks after a started cycle may turn into writes
      if (wc.is_write)
      begin
        next_cycle = CYC_WRITE;
        do_write = 1'b1;
      end
      else
      begin
        next_cycle = CYC_READ;
      end
    end
    write_strobe = do_write ? wc.lane_strobe : '0;
    next_last_strobe = do_write ? wc.lane_strobe : last_strobe;
    next_wcount = do_write ? wcount + `WCOUNT_W'(1) : wcount;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cycle <= CYC_IDLE;
      line_addr <= '0;
      last_strobe <= '0;
      wcount <= '0;
    end
    else
    begin
      cycle <= next_cycle;
      line_addr <= next_line_addr;
      last_strobe <= next_last_strobe;
      wcount <= next_wcount;
    end
  end

  // ----------------------------------------
  // Storage, one array per lane
  // ----------------------------------------
  for (genvar g = 0; g < `SRAM_LANES; g++)
  begin : g_lane
    logic [`SRAM_LANE_W-1:0] mem [`SRAM_DEPTH];

    always_ff @(posedge clk_i)
    begin
      if (write_strobe[g])
      begin
        mem[next_line_addr] <= dq_i[g*`SRAM_LANE_W +: `SRAM_LANE_W];
      end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
      begin
        dq_o[g*`SRAM_LANE_W +: `SRAM_LANE_W] <= '0;
      end
      else
      begin
        dq_o[g*`SRAM_LANE_W +: `SRAM_LANE_W] <= mem[next_line_addr];
      end
    end
  end

  // ----------------------------------------
  // Data pin drive, asynchronous to the clock
  // ----------------------------------------
  // Write and idle cycles mask the output enable; only a read may drive
  assign dq_oe_o = (cycle == CYC_READ) && !out_en_n_i;

  // ----------------------------------------
  // Register slave
  // ----------------------------------------
  logic waitreq;
  logic next_waitreq;
  logic next_ctrl_enable;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic bus_ack;
  logic bus_req;

  always_comb
  begin
    bus_req = avs_read_i || avs_write_i;
    bus_ack = !waitreq;
    next_waitreq = !(bus_req && waitreq);
    next_ctrl_enable = ctrl_enable;
    next_rdata = rdata;
    if (bus_req && waitreq)
    begin
      next_rdata = '0;
      case (avs_address_i)
        `REG_CTRL:
        begin
          next_rdata[`CTRL_ENABLE_BIT] = ctrl_enable;
        end
        `REG_STATUS:
        begin
          next_rdata[`STATUS_CYCLE_LSB +: 2] = cycle;
          next_rdata[`STATUS_STROBE_LSB +: `SRAM_LANES] = last_strobe;
        end
        `REG_WCOUNT:
        begin
          next_rdata[`WCOUNT_W-1:0] = wcount;
        end
        default:
        begin
          next_rdata = '0;
        end
      endcase
    end
    if (bus_ack && avs_write_i && avs_address_i == `REG_CTRL && avs_byteenable_i[0])
    begin
      next_ctrl_enable = avs_writedata_i[`CTRL_ENABLE_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      waitreq <= 1'b1;
      ctrl_enable <= `CTRL_ENABLE_RST;
      rdata <= '0;
    end
    else
    begin
      waitreq <= next_waitreq;
      ctrl_enable <= next_ctrl_enable;
      rdata <= next_rdata;
    end
  end

  assign avs_waitrequest_o = waitreq;
  assign avs_readdata_o = rdata;

endmodule

`default_nettype wire

// *** hdl/sram_write_decode_oe_control_note_placeholder.sv ***
`timescale 1ns/1ps

// *** hdl/write_ctl_if.sv ***
/*
  Interface carrying the write enable pins to the decoder and its result back.
  Assumes the package sram_pkg is compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

interface write_ctl_if;
  import sram_pkg::*;
  logic global_write_n;
  logic lane_write_gate_n;
  logic lane_a_write_n;
  logic lane_b_write_n;
  logic is_write;
  lane_mask_t lane_strobe;

  modport decoder (
    input global_write_n,
    input lane_write_gate_n,
    input lane_a_write_n,
    input lane_b_write_n,
    output is_write,
    output lane_strobe
  );

  modport user (
    output global_write_n,
    output lane_write_gate_n,
    output lane_a_write_n,
    output lane_b_write_n,
    input is_write,
    input lane_strobe
  );
endinterface

`default_nettype wire

// *** hdl/write_decode.sv ***
/*
  Combinational decode of global write, lane write gate and lane enables
  into a write/read decision and per-lane write strobes.
  Assumes the enable pins are already synchronous to the caller's clock.
*/
`timescale 1ns/1ps
`default_nettype none

module write_decode
  import sram_pkg::*;
(
  write_ctl_if.decoder ctl
);

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  always_comb
  begin
    ctl.lane_strobe = '0;
    if (!ctl.global_write_n)
    begin
      ctl.lane_strobe = '1;
    end
    else if (!ctl.lane_write_gate_n)
    begin
      ctl.lane_strobe[0] = !ctl.lane_a_write_n;
      ctl.lane_strobe[1] = !ctl.lane_b_write_n;
    end
    // Gate high with global write high reads whatever the lanes say
    ctl.is_write = |ctl.lane_strobe;
  end

endmodule

`default_nettype wire

// *** tb/dq_bus_model.sv ***
/*
  Controller side of the shared data wire: resolves both drivers.
  Undriven, the wire shows the inverse of its last driven value.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sram_cfg.svh"
module dq_bus_model
  import sram_pkg::*;
(
  input wire logic [`SRAM_DATA_W-1:0] dev_dq_i,
  input wire logic dev_oe_i,
  input wire logic [`SRAM_DATA_W-1:0] host_dq_i,
  input wire logic host_oe_i,
  output logic [`SRAM_DATA_W-1:0] wire_o,
  output logic clash_o
);
  logic [`SRAM_DATA_W-1:0] last = 18'h0;
  always @*
  begin
    if (host_oe_i)
      last = host_dq_i;
    else if (dev_oe_i)
      last = dev_dq_i;
  end
  assign wire_o = (host_oe_i || dev_oe_i) ? last : ~last;
  // Host and device driving the wire at the same time is a clash
  assign clash_o = host_oe_i && dev_oe_i;
endmodule
`default_nettype wire

// *** tb/sram_chk_sva.sv ***
/*
  Checker of cycle start and data drive at the block's pins.
  Bound to the top module; sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module sram_chk
  import sram_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic chip_sel_n_i,
  input wire logic processor_addr_strobe_n_i,
  input wire logic controller_addr_strobe_n_i,
  input wire logic global_write_n_i,
  input wire logic lane_write_gate_n_i,
  input wire logic lane_a_write_n_i,
  input wire logic lane_b_write_n_i,
  input wire logic out_en_n_i,
  input wire logic dq_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_proc;
    !processor_addr_strobe_n_i && !chip_sel_n_i;
  endsequence
  sequence s_ctrl;
    processor_addr_strobe_n_i && !controller_addr_strobe_n_i && !chip_sel_n_i;
  endsequence
  sequence s_cont_wr;
    processor_addr_strobe_n_i && controller_addr_strobe_n_i && !global_write_n_i;
  endsequence
  property p_oe_async;
    dq_oe_o |-> !out_en_n_i;
  endproperty
  a_oe_async: assert property (p_oe_async) else $error("drive without enable");
  property p_proc_read;
    s_proc |=> dq_oe_o == !out_en_n_i;
  endproperty
  a_proc_read: assert property (p_proc_read) else $error("strobe read drive");
  property p_gw_write;
    s_ctrl ##0 !global_write_n_i |=> !dq_oe_o;
  endproperty
  a_gw_write: assert property (p_gw_write) else $error("global write drives");
  property p_gate_read;
    s_ctrl ##0 (global_write_n_i && (lane_write_gate_n_i || (lane_a_write_n_i &&
      lane_b_write_n_i))) |=> dq_oe_o == !out_en_n_i;
  endproperty
  a_gate_read: assert property (p_gate_read) else $error("read drive wrong");
  property p_lane_write;
    s_ctrl ##0 (!lane_write_gate_n_i && !(lane_a_write_n_i && lane_b_write_n_i)) |=> !dq_oe_o;
  endproperty
  a_lane_write: assert property (p_lane_write) else $error("lane write drives");
  property p_desel;
    (!processor_addr_strobe_n_i || !controller_addr_strobe_n_i) && chip_sel_n_i |=> !dq_oe_o;
  endproperty
  a_desel: assert property (p_desel) else $error("deselect drives");
  property p_after_proc;
    s_proc ##1 s_cont_wr |=> !dq_oe_o;
  endproperty
  a_after_proc: assert property (p_after_proc) else $error("follow-on write drives");
  property p_write_masked;
    s_ctrl ##0 !global_write_n_i ##1 s_cont_wr ##0 !out_en_n_i |=> !dq_oe_o;
  endproperty
  a_write_masked: assert property (p_write_masked) else $error("enable not masked");
endmodule
bind sram_write_decode_oe_control sram_chk sram_chk_inst (
  .clk_i(clk_i),
  .rst_b_i(rst_b_i),
  .chip_sel_n_i(chip_sel_n_i),
  .processor_addr_strobe_n_i(processor_addr_strobe_n_i),
  .controller_addr_strobe_n_i(controller_addr_strobe_n_i),
  .global_write_n_i(global_write_n_i),
  .lane_write_gate_n_i(lane_write_gate_n_i),
  .lane_a_write_n_i(lane_a_write_n_i),
  .lane_b_write_n_i(lane_b_write_n_i),
  .out_en_n_i(out_en_n_i),
  .dq_oe_o(dq_oe_o)
);
`default_nettype wire

// *** tb/sram_write_decode_oe_control_tb.sv ***
/*
  Testbench: pin cycles and register accesses with expected values.
  Assumes the design, checker and data-wire model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sram_cfg.svh"
module sram_write_decode_oe_control_tb
  import sram_pkg::*;
;
  logic clk = 1'b0, rst_b = 1'b0, cs_n = 1'b0, proc_n = 1'b1, ctrl_n = 1'b1;
  logic gw_n = 1'b1, gate_n = 1'b1, a_n = 1'b1, b_n = 1'b1, oe_n = 1'b1, host_oe = 1'b0;
  logic avs_rd = 1'b0, avs_wr = 1'b0, dq_oe, clash, avs_wait;
  logic [17:0] addr = 18'h0, wdata = 18'h0, dq_bus, dq_o;
  logic [3:0] avs_addr = 4'h0, avs_be = 4'hF;
  logic [31:0] avs_wd = 32'h0, avs_rdata, q;
  logic [3:0] rows [6] = '{4'hC, 4'hB, 4'hA, 4'h9, 4'h8, 4'h7};
  logic [1:0] ln;
  int failures = 0, check_count = 0;
  initial forever #4 clk = ~clk;
  sram_write_decode_oe_control sram_write_decode_oe_control_inst (.clk_i(clk), .rst_b_i(rst_b),
    .chip_sel_n_i(cs_n), .processor_addr_strobe_n_i(proc_n), .controller_addr_strobe_n_i(ctrl_n),
    .global_write_n_i(gw_n), .lane_write_gate_n_i(gate_n), .lane_a_write_n_i(a_n),
    .lane_b_write_n_i(b_n), .out_en_n_i(oe_n), .addr_i(addr), .dq_i(dq_bus), .dq_o(dq_o),
    .dq_oe_o(dq_oe), .avs_address_i(avs_addr), .avs_read_i(avs_rd), .avs_write_i(avs_wr),
    .avs_writedata_i(avs_wd), .avs_byteenable_i(avs_be), .avs_readdata_o(avs_rdata),
    .avs_waitrequest_o(avs_wait));
  dq_bus_model dq_bus_model_inst (.dev_dq_i(dq_o), .dev_oe_i(dq_oe), .host_dq_i(wdata),
    .host_oe_i(host_oe), .wire_o(dq_bus), .clash_o(clash));
  task automatic close_out;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [1:0] lanes(input logic [3:0] w);
    if (!w[3])
      return 2'h3;
    return w[2] ? 2'h0 : ~w[1:0];
  endfunction
  // Strobes are {chip select, processor, controller}; enables {global, gate, B, A}
  task automatic pin(input logic [2:0] s, input logic [3:0] w, input logic oe, input logic [17:0] a,
    input logic [17:0] d);
    @(posedge clk);
    {cs_n, proc_n, ctrl_n} <= s;
    {gw_n, gate_n, b_n, a_n} <= w;
    oe_n <= oe;
    addr <= a;
    wdata <= d;
    host_oe <= (s[1] || oe) && (lanes(w) != 2'h0);
  endtask
  task automatic rd(input logic [17:0] a, input logic [17:0] exp);
    pin(3'h1, 4'hF, 1'b1, a, 18'h0);
    pin(3'h3, 4'hF, 1'b1, a, 18'h0);
    #1 chk("dq_o", {14'h0, exp}, {14'h0, dq_o});
    chk("dq_oe off", 32'h0, {31'h0, dq_oe});
    pin(3'h3, 4'hF, 1'b0, a, 18'h0);
    #1 chk("dq_oe on", 32'h1, {31'h0, dq_oe});
  endtask
  task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    {avs_addr, avs_rd, avs_wr, avs_wd} <= {a, !wr, wr, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_wait !== 1'b0 && n < 20);
    q = avs_rdata;
    if (avs_wait !== 1'b0)
    begin
      failures++;
      close_out();
    end
    {avs_rd, avs_wr} <= 2'h0;
  endtask
  always @(posedge clk)
    if (clash === 1'b1)
      chk("clash", 32'h0, 32'h1);
  initial
  begin
    #80000 failures++;
    close_out();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    avs(1'b0, `REG_CTRL, 32'h0);
    chk("ctrl", 32'h1, q);
    avs(1'b0, `REG_WCOUNT, 32'h0);
    chk("wcount", 32'h0, q);
    for (int i = 0; i < 6; i++)
    begin
      pin(3'h2, 4'h7, 1'b1, 18'(i), 18'h0);
      pin(3'h3, 4'h7, 1'b0, 18'(i), 18'h0);
      #1 chk("masked", 32'h0, {31'h0, dq_oe});
    end
    $display("write mask test done");
    for (int i = 0; i < 6; i++)
    begin
      pin(3'h2, rows[i], 1'b1, 18'(i), 18'h3FFFF);
      ln = lanes(rows[i]);
      rd(18'(i), {{9{ln[1]}}, {9{ln[0]}}});
    end
    $display("decode table test done");
    pin(3'h1, 4'h0, 1'b1, 18'h0, 18'h15555);
    rd(18'h0, 18'h0);
    pin(3'h1, 4'hF, 1'b1, 18'h1, 18'h0);
    pin(3'h3, 4'h7, 1'b1, 18'h1, 18'h12345);
    rd(18'h1, 18'h12345);
    pin(3'h6, 4'hF, 1'b0, 18'h2, 18'h0);
    pin(3'h3, 4'hF, 1'b0, 18'h2, 18'h0);
    #1 chk("deselect", 32'h0, {31'h0, dq_oe});
    $display("strobe test done");
    avs(1'b0, `REG_WCOUNT, 32'h0);
    chk("wcount", 32'd17, q);
    avs(1'b0, `REG_STATUS, 32'h0);
    chk("status", 32'hC, {28'h0, q[3:0]});
    avs(1'b1, 4'hC, 32'hFFFFFFFF);
    avs(1'b0, 4'hC, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("register test done");
    close_out();
  end
endmodule
`default_nettype wire
